/* File: hw/dec_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - data break halts after access, before next
// - data break return is first unexecuted instruction
// - breakpoint instruction halts when entry enabled
// - disabled entry makes breakpoint a no-op
// - software break taken before execution, re-enters
// - ignore-first-match never masks software breakpoint
// - debugger writes and locks icache, cacheable only
// - zero opcode traps only when enabled
// - trapped zero opcode sets its flag
// - single step runs one instruction then halts
// - trapped soft reset halts, sets hardware error
// - untrapped soft reset restarts normally
// - saved address undefined after hardware error
// - event-in falling edge breaks when armed
// - event-in break sets external flag
// - trace full break sets flag, saves next address
// - forced halt ignores mask and exceptions
// - forced halt sets debug request flag
// - causes other than forced halt honoured only when enabled, unmasked
// - each cause own flag, several together
module dec_top
  import dec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // core pipeline events, same clock
  input wire logic insn_valid_i,        // instruction at execute stage
  input wire logic [31:0] insn_pc_i,    // its address
  input wire logic [15:0] insn_op_i,    // its upper opcode halfword
  input wire logic insn_is_bkpt_i,      // decoded breakpoint instruction
  input wire logic insn_done_i,         // instruction retired this cycle
  input wire logic [31:0] next_pc_i,    // address of next unexecuted instruction
  input wire logic mem_done_i,          // memory operation completed
  input wire logic dbrk_match_i,        // data breakpoint comparator hit
  input wire logic soft_rst_req_i,      // any soft reset source, watchdog included
  input wire logic trace_full_i,        // memory trace buffer became full
  input wire logic excp_pending_i,      // exception would flush this instruction
  input wire logic debug_entry_mask_i,  // status register debug mask
  input wire logic [31:0] cpu_status_reg_i,
  input wire logic icache_cacheable_i,  // mmu marks target page cacheable
  input wire logic event_in_pin_n_i,    // asynchronous pin
  // to core
  output logic halt_o,                  // core held in debug halt
  output logic nop_bkpt_o,              // execute breakpoint as no-op
  output logic soft_rst_o,              // pass soft reset to the core
  output logic resume_o,                // one-cycle pulse: restart at resume_pc_o
  output logic [31:0] resume_pc_o,
  output logic [31:0] resume_sr_o,
  output logic icache_we_o,             // debugger icache word write pulse
  output logic icache_lock_o,
  output logic [31:0] icache_addr_o,
  output logic [31:0] icache_data_o
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RUN, HALT, STEP} dec_state_t;
  dec_state_t state_r;

  logic [CTL_W-1:0] ctrl_r;       // development_control_reg
  logic [ST_W-1:0] stat_r;        // development_status_reg
  logic [31:0] ret_addr_r;        // debug_return_address
  logic [31:0] ret_sr_r;          // debug_saved_status
  logic [31:0] debug_instruction_reg_r;           // debug_instruction_reg, also icache data
  logic exit_req_r;               // debugger asked to leave halt
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic halt_r;
  logic nop_r;
  logic srst_r;
  logic resume_r;
  logic icwe_r;
  logic iclk_r;
  logic ext_pend_r;               // latched event-in edge awaiting entry
  logic step_armed_r;             // stepping instruction has retired

  dec_evt_if evt ();

  // ---------------------------------------------------------------
  // helper decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  logic entry_ok;      // on-chip debug enabled and not masked
  logic wr_acc;
  logic rd_acc;
  logic c_dbk, c_swb, c_boz, c_ss, c_hwe, c_exb, c_tbf, c_dba;
  logic any_cause;
  logic [ST_W-1:0] cause_vec;

  assign entry_ok = ctrl_r[CTL_DBE] & ~debug_entry_mask_i;
  assign wr_acc = psel_i & penable_i & pwrite_i & ~pready_r;
  assign rd_acc = psel_i & penable_i & ~pwrite_i & ~pready_r;
  assign evt.arm = (ctrl_r[CTL_EIC_LO +: 2] == EIC_FALL_BREAK);

  dec_evt_edge u_evt (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .event_in_pin_n_i(event_in_pin_n_i),
    .evt(evt)
  );

  // cause detection; only evaluated while running or stepping
  always_comb begin
    c_dbk = entry_ok & dbrk_match_i & mem_done_i;
    // taken before execution; ignore-first-match plays no part here
    c_swb = entry_ok & insn_valid_i & insn_is_bkpt_i;
    c_boz = entry_ok & ctrl_r[CTL_TOZ] & insn_valid_i
            & (insn_op_i == ZERO_OPCODE) & ~insn_is_bkpt_i;
    // a flushing exception cancels software and zero-opcode breaks; single step is not cancelled
    if (excp_pending_i) begin
      c_swb = 1'b0;
      c_boz = 1'b0;
    end
    c_ss = entry_ok & (state_r == STEP) & step_armed_r & insn_valid_i;
    c_hwe = entry_ok & ctrl_r[CTL_TSR] & ~ctrl_r[CTL_MM] & soft_rst_req_i;
    c_exb = entry_ok & (ext_pend_r | evt.fall);
    c_tbf = entry_ok & ctrl_r[CTL_TBF] & trace_full_i;
    c_dba = ctrl_r[CTL_ABORT];
    cause_vec = '0;
    cause_vec[ST_DBK] = c_dbk;
    cause_vec[ST_SWB] = c_swb;
    cause_vec[ST_BOZ] = c_boz;
    cause_vec[ST_SSF] = c_ss;
    cause_vec[ST_HWE] = c_hwe;
    cause_vec[ST_EXB] = c_exb;
    cause_vec[ST_TBF] = c_tbf;
    cause_vec[ST_DBA] = c_dba;
    any_cause = (state_r != HALT) & (|cause_vec);
  end

  // ---------------------------------------------------------------
  // debug state machine
  // ---------------------------------------------------------------
  // halt entry, resume with optional single step
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r <= RUN;
      step_armed_r <= 1'b0;
    end else begin
      case (state_r)
        RUN: begin
          if (any_cause) begin
            state_r <= HALT;
          end
        end
        STEP: begin
          if (any_cause) begin
            state_r <= HALT;
            step_armed_r <= 1'b0;
          end else if (insn_done_i) begin
            step_armed_r <= 1'b1;  // one instruction retired, halt on next
          end
        end
        HALT: begin
          if (exit_req_r) begin
            state_r <= ctrl_r[CTL_SS] ? STEP : RUN;
            step_armed_r <= 1'b0;
          end
        end
        default: begin
          state_r <= RUN;
        end
      endcase
    end
  end

  // saved return address and status at entry
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ret_addr_r <= RET_RESET;
      ret_sr_r <= RET_RESET;
    end else if (any_cause) begin
      if (c_hwe) begin
        ret_addr_r <= UNDEF_WORD;
        ret_sr_r <= UNDEF_WORD;
      end else if (c_dbk) begin
        ret_addr_r <= next_pc_i;
        ret_sr_r <= cpu_status_reg_i;
      end else if (c_swb | c_boz) begin
        ret_addr_r <= insn_pc_i;
        ret_sr_r <= cpu_status_reg_i;
      end else begin
        ret_addr_r <= next_pc_i;
        ret_sr_r <= cpu_status_reg_i;
      end
    end else if (wr_acc & (state_r == HALT) & hit(paddr_i, DEC_RAR_ADDR)) begin
      ret_addr_r <= pwdata_i;       // debugger may move the return point
    end
  end

  // event-in edge held until entry can take it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ext_pend_r <= 1'b0;
    end else if (any_cause) begin
      ext_pend_r <= 1'b0;
    end else if (evt.fall) begin
      ext_pend_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // control register, status register
  // ---------------------------------------------------------------
  // abort and icache write strobe clear themselves
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTL_RESET;
    end else begin
      if (any_cause) begin
        ctrl_r[CTL_ABORT] <= 1'b0;
      end
      ctrl_r[CTL_ICW] <= 1'b0;
      if (wr_acc & hit(paddr_i, DEC_CTRL_ADDR)) begin
        ctrl_r <= pwdata_i[CTL_W-1:0];
      end
    end
  end

  // flags gather at entry, cleared by writing ones; a new cause beats the clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stat_r <= ST_RESET;
    end else begin
      stat_r[ST_HLT] <= (state_r == HALT) | any_cause;
      if (wr_acc & hit(paddr_i, DEC_STAT_ADDR)) begin
        stat_r[ST_DBA:0] <= (stat_r[ST_DBA:0] & ~pwdata_i[ST_DBA:0])
                            | (any_cause ? cause_vec[ST_DBA:0] : '0);
      end else if (any_cause) begin
        stat_r[ST_DBA:0] <= stat_r[ST_DBA:0] | cause_vec[ST_DBA:0];
      end
    end
  end

  // debug instruction word and exit request
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      debug_instruction_reg_r <= RET_RESET;
      exit_req_r <= 1'b0;
    end else begin
      exit_req_r <= 1'b0;
      if (wr_acc & hit(paddr_i, DEC_INST_ADDR)) begin
        debug_instruction_reg_r <= pwdata_i;
      end
      if (wr_acc & hit(paddr_i, DEC_MODE_ADDR) & pwdata_i[0] & (state_r == HALT)) begin
        exit_req_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, unmapped reads zero with error
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel_i & penable_i & ~pready_r;
      pslverr_r <= 1'b0;
      if (psel_i & penable_i & ~pready_r) begin
        prdata_r <= '0;
        if (rd_acc) begin
          case (paddr_i)
            DEC_CTRL_ADDR: prdata_r <= {{(32-CTL_W){1'b0}}, ctrl_r};
            DEC_STAT_ADDR: prdata_r <= {{(32-ST_W){1'b0}}, stat_r};
            DEC_RAR_ADDR: prdata_r <= ret_addr_r;
            DEC_RSR_ADDR: prdata_r <= ret_sr_r;
            DEC_INST_ADDR: prdata_r <= debug_instruction_reg_r;
            DEC_MODE_ADDR: prdata_r <= {30'h0000_0000, state_r};
            default: pslverr_r <= 1'b1;
          endcase
        end else if (!(hit(paddr_i, DEC_CTRL_ADDR) | hit(paddr_i, DEC_STAT_ADDR)
                   | hit(paddr_i, DEC_RAR_ADDR) | hit(paddr_i, DEC_RSR_ADDR)
                   | hit(paddr_i, DEC_INST_ADDR) | hit(paddr_i, DEC_MODE_ADDR))) begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // core-facing outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      halt_r <= 1'b0;
      nop_r <= 1'b0;
      srst_r <= 1'b0;
      resume_r <= 1'b0;
      icwe_r <= 1'b0;
      iclk_r <= 1'b0;
    end else begin
      halt_r <= any_cause | ((state_r == HALT) & ~exit_req_r);
      nop_r <= insn_valid_i & insn_is_bkpt_i & ~entry_ok;
      // trapped reset is swallowed; otherwise it passes through
      srst_r <= soft_rst_req_i & ~c_hwe;
      resume_r <= (state_r == HALT) & exit_req_r;
      icwe_r <= ctrl_r[CTL_ICW] & icache_cacheable_i;
      iclk_r <= ctrl_r[CTL_ICL] & icache_cacheable_i;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign halt_o = halt_r;
  assign nop_bkpt_o = nop_r;
  assign soft_rst_o = srst_r;
  assign resume_o = resume_r;
  assign resume_pc_o = ret_addr_r;
  assign resume_sr_o = ret_sr_r;
  assign icache_we_o = icwe_r;
  assign icache_lock_o = iclk_r;
  assign icache_addr_o = ret_addr_r;
  assign icache_data_o = debug_instruction_reg_r;
endmodule

/* File: hw/dec_pkg.sv */
package dec_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] DEC_CTRL_ADDR = 8'h00;   // development_control_reg
  localparam logic [7:0] DEC_STAT_ADDR = 8'h04;   // development_status_reg
  localparam logic [7:0] DEC_RAR_ADDR = 8'h08;    // debug_return_address
  localparam logic [7:0] DEC_RSR_ADDR = 8'h0C;    // debug_saved_status
  localparam logic [7:0] DEC_INST_ADDR = 8'h10;   // debug_instruction_reg
  localparam logic [7:0] DEC_MODE_ADDR = 8'h14;   // halt state and exit command

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTL_DBE = 0;      // debug_entry_enable
  localparam int CTL_MM = 1;       // monitor mode select
  localparam int CTL_IFM = 2;      // ignore_first_match
  localparam int CTL_TOZ = 3;      // trap_zero_opcode_enable
  localparam int CTL_SS = 4;       // single step
  localparam int CTL_TSR = 5;      // trap_soft_reset_enable
  localparam int CTL_EIC_LO = 6;   // event_in_control, two bits
  localparam int CTL_TBF = 8;      // break on trace buffer full
  localparam int CTL_ABORT = 9;    // forced halt, self clearing
  localparam int CTL_ICW = 10;     // debugger icache write strobe, self clearing
  localparam int CTL_ICL = 11;     // lock the written icache page
  localparam int CTL_W = 12;
  localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;

  // ---------------------------------------------------------------
  // status field positions, one per cause, plus the halted bit
  // ---------------------------------------------------------------
  localparam int ST_DBK = 0;   // data breakpoint
  localparam int ST_SWB = 1;   // software breakpoint
  localparam int ST_BOZ = 2;   // zero_opcode_break_flag
  localparam int ST_SSF = 3;   // single step
  localparam int ST_HWE = 4;   // hardware_error_flag
  localparam int ST_EXB = 5;   // external_break_flag
  localparam int ST_TBF = 6;   // trace_buffer_full_flag
  localparam int ST_DBA = 7;   // debug_request_break_flag
  localparam int ST_HLT = 8;   // currently halted
  localparam int ST_W = 9;
  localparam logic [ST_W-1:0] ST_RESET = 9'h000;

  localparam logic [1:0] EIC_FALL_BREAK = 2'b01;
  localparam logic [15:0] ZERO_OPCODE = 16'h0000;
  localparam logic [31:0] RET_RESET = 32'h0000_0000;
  localparam logic [31:0] UNDEF_WORD = 32'hDEAD_0000;  // marks undefined saves
endpackage

/* File: hw/dec_evt_if.sv */
`timescale 1ns/10ps
// event-in pin path between the top and its edge detector
interface dec_evt_if;
  logic arm;     // event-in control selects falling-edge break
  logic fall;    // one-cycle pulse on synchronised falling edge
  modport top (output arm, input fall);
  modport det (input arm, output fall);
endinterface

/* File: hw/dec_evt_edge.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// event-in pin synchroniser and falling-edge detector
// ---------------------------------------------------------------
module dec_evt_edge (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic event_in_pin_n_i,
  dec_evt_if.det evt
);
  logic s1_r;    // first stage, read only by second stage
  logic s2_r;    // second stage
  logic s3_r;    // previous level for edge detection

  // two flops before any logic; resets high since the pin idles high
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= event_in_pin_n_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a low of one cycle may be missed by the sampler; the source keeps it longer
  assign evt.fall = evt.arm & s3_r & ~s2_r;
endmodule

/* File: test/dec_evt_src.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// event-in source standing in for the external trigger
// ---------------------------------------------------------------
module dec_evt_src (
  input wire logic mclk_i,
  input wire logic go_i,
  output logic pin_n_o
);
  int low_cnt;  // cycles left with the pin pulled low
  // a go request pulls the pin low for four cycles, well past the minimum
  always_ff @(posedge mclk_i) begin
    if (go_i) begin
      low_cnt <= 4;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  // pin rests at its pull-up level between events
  assign pin_n_o = !(low_cnt > 0);
endmodule

/* File: test/dec_top_checker.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// entry cause checker
// ---------------------------------------------------------------
module dec_top_checker
  import dec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_op_i,
  input wire logic insn_is_bkpt_i,
  input wire logic mem_done_i,
  input wire logic dbrk_match_i,
  input wire logic soft_rst_req_i,
  input wire logic excp_pending_i,
  input wire logic debug_entry_mask_i,
  input wire logic event_in_pin_n_i,
  input wire logic halt_o,
  input wire logic nop_bkpt_o,
  input wire logic soft_rst_o
);
  logic [CTL_W-1:0] c;  // shadow of the control word
  logic en;             // entry enabled and unmasked
  // shadow follows completed writes; self-clearing bits are simply kept
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      c <= CTL_RESET;
    end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == DEC_CTRL_ADDR) begin
      c <= pwdata_i[CTL_W-1:0];
    end
  end
  assign en = c[CTL_DBE] && !debug_entry_mask_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_dbrk;
    dbrk_match_i && mem_done_i && en && !halt_o |=> halt_o;
  endproperty
  a_dbrk: assert property (p_dbrk) else $error("data break missed");
  property p_swb;
    insn_valid_i && insn_is_bkpt_i && en && !excp_pending_i && !halt_o |=> halt_o;
  endproperty
  a_swb: assert property (p_swb) else $error("breakpoint missed");
  property p_nop;
    insn_valid_i && insn_is_bkpt_i && !en && !halt_o |=> !halt_o && nop_bkpt_o;
  endproperty
  a_nop: assert property (p_nop) else $error("disabled breakpoint halted");
  property p_zero;
    insn_valid_i && insn_op_i == ZERO_OPCODE && c[CTL_TOZ] && en && !excp_pending_i
      && !halt_o |=> halt_o;
  endproperty
  a_zero: assert property (p_zero) else $error("zero opcode missed");
  property p_hwe;
    soft_rst_req_i && c[CTL_TSR] && !c[CTL_MM] && en && !halt_o |=> halt_o && !soft_rst_o;
  endproperty
  a_hwe: assert property (p_hwe) else $error("soft reset not trapped");
  property p_rst;
    soft_rst_req_i && (!c[CTL_TSR] || c[CTL_MM]) |=> soft_rst_o;
  endproperty
  a_rst: assert property (p_rst) else $error("soft reset not passed");
  property p_evt;
    $fell(event_in_pin_n_i) && c[CTL_EIC_LO+1:CTL_EIC_LO] == EIC_FALL_BREAK && en && !halt_o
      |-> ##[2:6] halt_o;
  endproperty
  a_evt: assert property (p_evt) else $error("event-in missed");
  property p_abort;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == DEC_CTRL_ADDR
      && pwdata_i[CTL_ABORT] |-> ##[1:3] halt_o;
  endproperty
  a_abort: assert property (p_abort) else $error("forced halt missed");
endmodule

bind dec_top dec_top_checker u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .insn_valid_i(insn_valid_i), .insn_op_i(insn_op_i), .insn_is_bkpt_i(insn_is_bkpt_i),
  .mem_done_i(mem_done_i), .dbrk_match_i(dbrk_match_i), .soft_rst_req_i(soft_rst_req_i),
  .excp_pending_i(excp_pending_i), .debug_entry_mask_i(debug_entry_mask_i),
  .event_in_pin_n_i(event_in_pin_n_i), .halt_o(halt_o), .nop_bkpt_o(nop_bkpt_o),
  .soft_rst_o(soft_rst_o)
);

/* File: test/dec_top_bench.sv */
`timescale 1ns/10ps
module dec_top_bench;
  import dec_pkg::*;
  logic mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, resume_pc_o;
  logic insn_valid_i, insn_is_bkpt_i, insn_done_i, mem_done_i, dbrk_match_i;
  logic soft_rst_req_i, trace_full_i, excp_pending_i, debug_entry_mask_i;
  logic [15:0] insn_op_i;
  logic event_in_pin_n_i, evt_go, halt_o, resume_o, icache_we_o, icache_lock_o;
  logic [31:0] resume_sr_o, icache_addr_o, icache_data_o;
  int miscompares, n_checks;
  // ---------------------------------------------------------------
  // design, event source and clock
  // ---------------------------------------------------------------
  dec_top dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .insn_valid_i(insn_valid_i),
    .insn_pc_i(32'h0000_0100), .insn_op_i(insn_op_i), .insn_is_bkpt_i(insn_is_bkpt_i),
    .insn_done_i(insn_done_i), .next_pc_i(32'h0000_0104), .mem_done_i(mem_done_i),
    .dbrk_match_i(dbrk_match_i), .soft_rst_req_i(soft_rst_req_i),
    .trace_full_i(trace_full_i), .excp_pending_i(excp_pending_i),
    .debug_entry_mask_i(debug_entry_mask_i), .cpu_status_reg_i(32'h0000_00A5),
    .icache_cacheable_i(1'b1), .event_in_pin_n_i(event_in_pin_n_i), .halt_o(halt_o),
    .nop_bkpt_o(), .soft_rst_o(), .resume_o(resume_o), .resume_pc_o(resume_pc_o),
    .resume_sr_o(resume_sr_o), .icache_we_o(icache_we_o), .icache_lock_o(icache_lock_o),
    .icache_addr_o(icache_addr_o), .icache_data_o(icache_data_o)
  );
  dec_evt_src u_evt (.mclk_i(mclk_i), .go_i(evt_go), .pin_n_o(event_in_pin_n_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; an idle edge first keeps psel from being driven twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] d, output logic e);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize;
    end
    d = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask
  // one-cycle core event: 0 bkpt, 1 zero op, 2 data match, 3 soft reset, 4 trace, 5 retire
  task ev(input logic [5:0] m);
    @(posedge mclk_i);
    insn_valid_i <= m[0] | m[1] | m[5];
    insn_is_bkpt_i <= m[0];
    insn_op_i <= m[1] ? ZERO_OPCODE : 16'h1234;
    {dbrk_match_i, mem_done_i} <= {m[2], m[2]};
    {soft_rst_req_i, trace_full_i, insn_done_i} <= {m[3], m[4], m[5]};
    @(posedge mclk_i);
    {insn_valid_i, insn_is_bkpt_i, dbrk_match_i, mem_done_i} <= 4'h0;
    {soft_rst_req_i, trace_full_i, insn_done_i} <= 3'h0;
    insn_op_i <= 16'h1234;
    repeat (3) @(posedge mclk_i);
  endtask
  // status check, then return address and exit when halted, then clear flags
  task trip(input string nm, input logic [8:0] st, input logic [31:0] ra);
    logic [31:0] d;
    int n;
    rd(DEC_STAT_ADDR, d);
    chk(nm, d, {23'h0, st});
    if (st[ST_HLT]) begin
      if (ra !== 32'h0) begin
        rd(DEC_RAR_ADDR, d);
        chk("return_addr", d, ra);
      end
      wr(DEC_MODE_ADDR, 32'h0000_0001);
      n = 0;
      while (resume_o !== 1'b1 && n < 20) begin
        @(posedge mclk_i);
        n++;
      end
      if (n >= 20) begin
        miscompares++;
        summarize;
      end
      chk("resume", {31'h0, resume_o}, 32'h1);
      if (ra !== 32'h0 && ra !== UNDEF_WORD) begin
        chk("resume_pc", resume_pc_o, ra);
        chk("resume_sr", resume_sr_o, 32'h0000_00A5);
      end
    end
    wr(DEC_STAT_ADDR, 32'h0000_00FF);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs;
    logic [31:0] d;
    logic e;
    rd(DEC_STAT_ADDR, d);
    chk("stat_reset", d, 32'h0);
    apb(1'b0, 8'h20, 32'h0, d, e);
    chk("unmapped", {d[30:0], e}, 32'h1);
    $display("regs done");
  endtask
  task t_swb;
    wr(DEC_CTRL_ADDR, 32'h0000_0005);
    debug_entry_mask_i <= 1'b1;
    ev(6'h01);
    trip("swb_masked", 9'h000, 32'h0);
    debug_entry_mask_i <= 1'b0;
    ev(6'h01);
    // original opcode goes back through the instruction register before exit
    wr(DEC_INST_ADDR, 32'h1234_0000);
    trip("swb", 9'h102, 32'h0000_0100);
    wr(DEC_CTRL_ADDR, 32'h0000_0000);
    ev(6'h01);
    trip("swb_off", 9'h000, 32'h0);
    $display("swb done");
  endtask
  task t_dbrk;
    wr(DEC_CTRL_ADDR, 32'h0000_0101);
    ev(6'h04);
    trip("dbrk", 9'h101, 32'h0000_0104);
    ev(6'h14);
    trip("dbrk_tbf", 9'h141, 32'h0000_0104);
    $display("dbrk done");
  endtask
  task t_zero;
    wr(DEC_CTRL_ADDR, 32'h0000_0001);
    ev(6'h02);
    trip("zero_off", 9'h000, 32'h0);
    wr(DEC_CTRL_ADDR, 32'h0000_0009);
    ev(6'h02);
    wr(DEC_INST_ADDR, {ZERO_OPCODE, 16'h1234});
    wr(DEC_CTRL_ADDR, 32'h0000_0C09);
    @(posedge mclk_i);
    chk("icache_we", {31'h0, icache_we_o}, 32'h1);
    chk("icache_lock", {31'h0, icache_lock_o}, 32'h1);
    chk("icache_data", icache_data_o, {ZERO_OPCODE, 16'h1234});
    chk("icache_addr", icache_addr_o, 32'h0000_0100);
    trip("zero", 9'h104, 32'h0000_0100);
    $display("zero done");
  endtask
  task t_hwe;
    wr(DEC_CTRL_ADDR, 32'h0000_0021);
    ev(6'h08);
    trip("hwe", 9'h110, UNDEF_WORD);
    wr(DEC_CTRL_ADDR, 32'h0000_0023);
    ev(6'h08);
    trip("rst_pass", 9'h000, 32'h0);
    $display("hwe done");
  endtask
  task t_evt;
    wr(DEC_CTRL_ADDR, 32'h0000_0041);
    evt_go <= 1'b1;
    @(posedge mclk_i);
    evt_go <= 1'b0;
    repeat (8) @(posedge mclk_i);
    trip("evt", 9'h120, 32'h0);
    $display("evt done");
  endtask
  // forced halt under mask and pending exception, then one step
  task t_abort_step;
    debug_entry_mask_i <= 1'b1;
    excp_pending_i <= 1'b1;
    wr(DEC_CTRL_ADDR, 32'h0000_0211);
    repeat (3) @(posedge mclk_i);
    {debug_entry_mask_i, excp_pending_i} <= 2'b00;
    trip("abort", 9'h180, 32'h0000_0104);
    // step-over is left to the debugger's pc breakpoints
    ev(6'h20);
    chk("step_run", {31'h0, halt_o}, 32'h0);
    ev(6'h20);
    trip("step", 9'h108, 32'h0000_0104);
    wr(DEC_CTRL_ADDR, 32'h0000_0000);
    $display("abort_step done");
  endtask
  initial begin
    {sys_rst_i, psel_i, penable_i, pwrite_i, insn_valid_i, insn_is_bkpt_i} = 6'h20;
    {insn_done_i, mem_done_i, dbrk_match_i, soft_rst_req_i, trace_full_i} = 5'h00;
    {excp_pending_i, debug_entry_mask_i, evt_go} = 3'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    insn_op_i = 16'h1234;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_swb;
    t_dbrk;
    t_zero;
    t_hwe;
    t_evt;
    t_abort_step;
    summarize;
  end
endmodule
